// ---- hdl/i2cxc_pkg.sv ----
// constants and types shared by both ends of the i2c slave extended-config link
package i2cxc_pkg;
   // register offsets
   localparam logic [7:0] XCFG_OFS = 8'hc8;
   localparam logic [7:0] XSTAT_OFS = 8'hc9;
   localparam logic [7:0] ADDR_OFS = 8'hca;
   // field positions
   localparam int XCFG_HW_POS = 0;
   localparam int XCFG_BUF_POS = 1;
   localparam int XCFG_SUP_POS = 3;
   localparam int XSTAT_BUSY_POS = 0;
   localparam int XSTAT_DIR_POS = 1;
   // reset values and writable masks
   localparam logic [7:0] XCFG_RST = 8'h00;
   localparam logic [7:0] ADDR_RST = 8'h00;
   localparam logic [7:0] XCFG_MASK = 8'h0b;
   localparam logic [7:0] ADDR_MASK = 8'h7f;
   // buffer geometry
   localparam int RAM_DEPTH = 32;
   localparam int PTR_W = 5;
   // bus timing at the 5 ns system clock, least times rounded up
   localparam int CLK_PERIOD_NS = 5;
   localparam int T_LOW_NS = 1300;
   localparam int T_HIGH_NS = 600;
   localparam int LOW_CYC = (T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HIGH_CYC = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [8:0] LOW_CNT = 9'(LOW_CYC);
   localparam logic [8:0] HIGH_CNT = 9'(HIGH_CYC);
   // master commands
   typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ, CMD_STOP} i2cxc_cmd_t;
endpackage

// ---- hdl/i2cxc_if.sv ----
// open-drain i2c link plus link clock between master end and slave end
`timescale 1ns/10ps
interface i2cxc_if;
   logic lnk_clk;
   logic scl_m_o;
   logic scl_m_oe;
   logic sda_m_o;
   logic sda_m_oe;
   logic scl_s_o;
   logic scl_s_oe;
   logic sda_s_o;
   logic sda_s_oe;
   logic scl;
   logic sda;
   // wired-and with pull-up
   assign scl = (scl_m_oe ? scl_m_o : 1'b1) & (scl_s_oe ? scl_s_o : 1'b1);
   assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);
   modport master (output lnk_clk, output scl_m_o, output scl_m_oe, output sda_m_o,
                   output sda_m_oe, input scl, input sda);
   modport slave (input lnk_clk, input scl, input sda, output scl_s_o, output scl_s_oe,
                  output sda_s_o, output sda_s_oe);
endinterface

// ---- hdl/i2cxc_mst.sv ----
// i2c master end: byte engine with clock stretching, drives the link clock
`timescale 1ns/10ps
module i2cxc_mst (
   // system
   input wire logic i_clk,
   input wire logic i_rst_n,
   // link
   i2cxc_if.master bus,
   // command port
   input wire logic i_cmd_valid,
   input wire i2cxc_pkg::i2cxc_cmd_t i_cmd,
   input wire logic [7:0] i_cmd_data,
   output logic o_ready,
   // read answer
   output logic o_rd_valid,
   output logic [7:0] o_rd_data,
   output logic o_ack_seen
);
   import i2cxc_pkg::*;

   typedef enum logic [3:0] {M_IDLE, M_HOLD, M_STA_A, M_STA_B, M_STA_C, M_BIT_LO, M_BIT_HI,
                             M_STO_A, M_STO_B, M_STO_C} i2cxc_mst_st_t;
   typedef struct packed {
      i2cxc_mst_st_t st;
      logic [8:0] cnt;
      logic [3:0] bcnt;
      logic [8:0] tx;
      logic [8:0] rx;
      logic scl_oe;
      logic sda_oe;
      logic scl_s1;
      logic scl_s2;
      logic sda_s1;
      logic sda_s2;
      logic lclk;
      logic ready;
      logic rd_valid;
      logic [7:0] rd_data;
      logic ack_seen;
   } i2cxc_mst_t;

   i2cxc_mst_t r_r;
   i2cxc_mst_t r_nxt;
   logic done;

   always_comb begin
      r_nxt = r_r;
      // link clock is the system clock divided by two
      // written as a branch so an unknown power-up level still starts the divider
      if (r_r.lclk) begin
         r_nxt.lclk = 1'b0;
      end else begin
         r_nxt.lclk = 1'b1;
      end
      r_nxt.scl_s1 = bus.scl;
      r_nxt.scl_s2 = r_r.scl_s1;
      r_nxt.sda_s1 = bus.sda;
      r_nxt.sda_s2 = r_r.sda_s1;
      r_nxt.rd_valid = 1'b0;
      done = (r_r.cnt == 9'h000);
      r_nxt.cnt = done ? r_r.cnt : r_r.cnt - 9'h001;
      unique case (r_r.st)
         M_IDLE, M_HOLD: begin
            if (i_cmd_valid && r_r.ready) begin
               r_nxt.ready = 1'b0;
               r_nxt.cnt = LOW_CNT;
               r_nxt.bcnt = 4'h0;
               unique case (i_cmd)
                  CMD_START: begin
                     r_nxt.tx = {i_cmd_data, 1'b1};
                     r_nxt.sda_oe = 1'b0;
                     r_nxt.st = M_STA_A;
                  end
                  CMD_WRITE: begin
                     r_nxt.tx = {i_cmd_data, 1'b1};
                     r_nxt.sda_oe = ~i_cmd_data[7];
                     r_nxt.st = M_BIT_LO;
                  end
                  CMD_READ: begin
                     r_nxt.tx = {8'hff, ~i_cmd_data[0]};
                     r_nxt.sda_oe = 1'b0;
                     r_nxt.st = M_BIT_LO;
                  end
                  CMD_STOP: begin
                     r_nxt.sda_oe = 1'b1;
                     r_nxt.st = M_STO_A;
                  end
               endcase
            end
         end
         M_STA_A: if (done) begin
            r_nxt.scl_oe = 1'b0;
            r_nxt.cnt = HIGH_CNT;
            r_nxt.st = M_STA_B;
         end
         M_STA_B: begin
            if (!r_r.scl_s2) begin
               r_nxt.cnt = HIGH_CNT;
            end else if (done) begin
               r_nxt.sda_oe = 1'b1;
               r_nxt.cnt = HIGH_CNT;
               r_nxt.st = M_STA_C;
            end
         end
         M_STA_C: if (done) begin
            r_nxt.scl_oe = 1'b1;
            r_nxt.sda_oe = ~r_r.tx[8];
            r_nxt.cnt = LOW_CNT;
            r_nxt.st = M_BIT_LO;
         end
         M_BIT_LO: if (done) begin
            r_nxt.scl_oe = 1'b0;
            r_nxt.cnt = HIGH_CNT;
            r_nxt.st = M_BIT_HI;
         end
         M_BIT_HI: begin
            // high time counts only once a stretching slave lets go
            if (!r_r.scl_s2) begin
               r_nxt.cnt = HIGH_CNT;
            end else if (done) begin
               r_nxt.rx = {r_r.rx[7:0], r_r.sda_s2};
               r_nxt.tx = {r_r.tx[7:0], 1'b1};
               r_nxt.scl_oe = 1'b1;
               r_nxt.cnt = LOW_CNT;
               if (r_r.bcnt == 4'h8) begin
                  r_nxt.sda_oe = 1'b0;
                  r_nxt.ready = 1'b1;
                  r_nxt.rd_valid = 1'b1;
                  r_nxt.rd_data = r_r.rx[7:0];
                  r_nxt.ack_seen = ~r_r.sda_s2;
                  r_nxt.st = M_HOLD;
               end else begin
                  r_nxt.sda_oe = ~r_r.tx[7];
                  r_nxt.bcnt = r_r.bcnt + 4'h1;
                  r_nxt.st = M_BIT_LO;
               end
            end
         end
         M_STO_A: if (done) begin
            r_nxt.scl_oe = 1'b0;
            r_nxt.cnt = HIGH_CNT;
            r_nxt.st = M_STO_B;
         end
         M_STO_B: begin
            if (!r_r.scl_s2) begin
               r_nxt.cnt = HIGH_CNT;
            end else if (done) begin
               r_nxt.sda_oe = 1'b0;
               r_nxt.cnt = HIGH_CNT;
               r_nxt.st = M_STO_C;
            end
         end
         M_STO_C: if (done) begin
            r_nxt.ready = 1'b1;
            r_nxt.st = M_IDLE;
         end
         default: r_nxt.st = M_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         r_r <= '0;
         r_r.ready <= 1'b1;
         // link clock runs through reset so the slave end can sync its reset
         r_r.lclk <= r_nxt.lclk;
      end else begin
         r_r <= r_nxt;
      end
   end

   assign bus.lnk_clk = r_r.lclk;
   assign bus.scl_m_o = 1'b0;
   assign bus.sda_m_o = 1'b0;
   assign bus.scl_m_oe = r_r.scl_oe;
   assign bus.sda_m_oe = r_r.sda_oe;
   assign o_ready = r_r.ready;
   assign o_rd_valid = r_r.rd_valid;
   assign o_rd_data = r_r.rd_data;
   assign o_ack_seen = r_r.ack_seen;
endmodule

// ---- hdl/i2cxc_dev.sv ----
// i2c slave end: extended config, status, hardware address compare, 32-byte buffer
`timescale 1ns/10ps
module i2cxc_dev (
   // system
   input wire logic i_clk,
   input wire logic i_rst_n,
   // link
   i2cxc_if.slave bus,
   // cpu io registers
   input wire logic i_enable,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   // byte service
   output logic o_byte_done,
   output logic o_addr_byte,
   output logic [7:0] o_rx_byte,
   input wire logic i_svc,
   input wire logic i_svc_ack,
   input wire logic [7:0] i_svc_data
);
   import i2cxc_pkg::*;

   typedef enum logic [2:0] {L_IDLE, L_ADDR, L_RX, L_STALL, L_ACK, L_TX, L_TX_ACK} i2cxc_lst_t;
   typedef struct packed {
      i2cxc_lst_t st;
      logic scl_oe;
      logic sda_oe;
      logic [7:0] sh;
      logic [3:0] bcnt;
      logic rw, ack, cpu_ack, first, mack, to_tx, wait_cpu, busy, dir;
      logic [5:0] cp;
      logic [4:0] bp;
      logic ev_tgl, ev_addr;
      logic [7:0] tx_hold;
      logic scl_s1, scl_s2, sda_s1, sda_s2, scl_q, sda_q;
      logic [10:0] cfg_s1, cfg_s2;
      logic flag_s1, flag_s2, go_s1, go_s2, go_seen;
   } i2cxc_link_t;
   typedef struct packed {
      logic [7:0] xcfg;
      logic [7:0] oaddr;
      logic en, flag, addr_flag;
      logic [7:0] rx_byte;
      logic ev_s1, ev_s2, ev_s3;
      logic busy_s1, busy_s2, dir_s1, dir_s2;
      logic go_tgl, go_ack;
      logic [7:0] go_data;
      logic [7:0] rdata;
   } i2cxc_sys_t;

   i2cxc_link_t r_r, r_nxt;
   i2cxc_sys_t s_r, s_nxt;
   logic [7:0] ram [RAM_DEPTH];
   logic ram_we;
   logic [7:0] rd_byte;
   logic [7:0] xstat;
   logic lrst_s1_n, lrst_s2_n;
   logic rise, fall, start, stop, go_ev, en, hw, buf_m, sup, irq;
   logic [6:0] own;

   // pointer stops at the boundary so overrun writes are discarded
   function automatic logic [5:0] ptr_inc(input logic [5:0] p);
      return p[5] ? p : p + 6'h01;
   endfunction

   assign rd_byte = r_r.cp[5] ? 8'hff : ram[r_r.cp[PTR_W-1:0]];

   always_comb begin
      r_nxt = r_r;
      ram_we = 1'b0;
      r_nxt.scl_s1 = bus.scl;
      r_nxt.scl_s2 = r_r.scl_s1;
      r_nxt.sda_s1 = bus.sda;
      r_nxt.sda_s2 = r_r.sda_s1;
      r_nxt.scl_q = r_r.scl_s2;
      r_nxt.sda_q = r_r.sda_s2;
      r_nxt.cfg_s1 = {s_r.en, s_r.xcfg[XCFG_SUP_POS], s_r.xcfg[XCFG_BUF_POS],
                      s_r.xcfg[XCFG_HW_POS], s_r.oaddr[6:0]};
      r_nxt.cfg_s2 = r_r.cfg_s1;
      r_nxt.flag_s1 = s_r.flag;
      r_nxt.flag_s2 = r_r.flag_s1;
      r_nxt.go_s1 = s_r.go_tgl;
      r_nxt.go_s2 = r_r.go_s1;
      r_nxt.go_seen = r_r.go_s2;
      {en, sup, buf_m, hw, own} = r_r.cfg_s2;
      rise = r_r.scl_s2 & ~r_r.scl_q;
      fall = ~r_r.scl_s2 & r_r.scl_q;
      start = r_r.scl_s2 & r_r.scl_q & r_r.sda_q & ~r_r.sda_s2;
      stop = r_r.scl_s2 & r_r.scl_q & ~r_r.sda_q & r_r.sda_s2;
      go_ev = r_r.go_s2 != r_r.go_seen;
      irq = buf_m ? ~sup : 1'b1;
      unique case (r_r.st)
         L_IDLE: ;
         L_ADDR: begin
            if (rise) begin
               r_nxt.sh = {r_r.sh[6:0], r_r.sda_s2};
               r_nxt.bcnt = r_r.bcnt + 4'h1;
            end else if (fall && r_r.bcnt == 4'h8) begin
               r_nxt.rw = r_r.sh[0];
               r_nxt.first = 1'b1;
               r_nxt.to_tx = 1'b0;
               r_nxt.ev_addr = 1'b1;
               if (hw) begin
                  if (r_r.sh[7:1] != own) begin
                     r_nxt.st = L_IDLE;
                  end else begin
                     r_nxt.busy = 1'b1;
                     r_nxt.dir = r_r.sh[0];
                     r_nxt.ack = 1'b1;
                     r_nxt.cpu_ack = 1'b0;
                     if (!buf_m) begin
                        r_nxt.ev_tgl = ~r_r.ev_tgl;
                        r_nxt.scl_oe = 1'b1;
                        r_nxt.wait_cpu = 1'b1;
                        r_nxt.st = L_STALL;
                     end else begin
                        r_nxt.ev_tgl = r_r.ev_tgl ^ irq;
                        r_nxt.sda_oe = 1'b1;
                        r_nxt.st = L_ACK;
                     end
                  end
               end else begin
                  r_nxt.ev_tgl = ~r_r.ev_tgl;
                  r_nxt.cpu_ack = 1'b1;
                  r_nxt.scl_oe = 1'b1;
                  r_nxt.wait_cpu = 1'b1;
                  r_nxt.st = L_STALL;
               end
            end
         end
         L_RX: begin
            if (rise) begin
               r_nxt.sh = {r_r.sh[6:0], r_r.sda_s2};
               r_nxt.bcnt = r_r.bcnt + 4'h1;
            end else if (fall && r_r.bcnt == 4'h8) begin
               r_nxt.ev_addr = 1'b0;
               if (buf_m) begin
                  r_nxt.ack = 1'b1;
                  r_nxt.cpu_ack = 1'b0;
                  if (r_r.first) begin
                     r_nxt.first = 1'b0;
                     r_nxt.ack = (r_r.sh[7:5] == 3'b000);
                     if (r_r.sh[7:5] == 3'b000) begin
                        r_nxt.bp = r_r.sh[PTR_W-1:0];
                        r_nxt.cp = {1'b0, r_r.sh[PTR_W-1:0]};
                     end
                  end else begin
                     ram_we = ~r_r.cp[5];
                     r_nxt.cp = ptr_inc(r_r.cp);
                  end
                  if (irq && r_r.flag_s2) begin
                     r_nxt.scl_oe = 1'b1;
                     r_nxt.wait_cpu = 1'b0;
                     r_nxt.st = L_STALL;
                  end else begin
                     r_nxt.ev_tgl = r_r.ev_tgl ^ irq;
                     r_nxt.sda_oe = r_nxt.ack;
                     r_nxt.st = L_ACK;
                  end
               end else begin
                  r_nxt.ev_tgl = ~r_r.ev_tgl;
                  r_nxt.cpu_ack = 1'b1;
                  r_nxt.scl_oe = 1'b1;
                  r_nxt.wait_cpu = 1'b1;
                  r_nxt.st = L_STALL;
               end
            end
         end
         L_STALL: begin
            // scl held low until the cpu answers or clears the pending flag
            if (r_r.wait_cpu ? go_ev : !r_r.flag_s2) begin
               r_nxt.scl_oe = 1'b0;
               if (!r_r.wait_cpu) begin
                  r_nxt.ev_tgl = ~r_r.ev_tgl;
               end else begin
                  r_nxt.tx_hold = s_r.go_data;
               end
               if (r_r.wait_cpu && r_r.cpu_ack) begin
                  r_nxt.ack = s_r.go_ack;
               end
               if (r_r.to_tx) begin
                  r_nxt.sh = r_r.wait_cpu ? s_r.go_data : rd_byte;
                  r_nxt.sda_oe = ~r_nxt.sh[7];
                  r_nxt.bcnt = 4'h0;
                  if (!r_r.wait_cpu) begin
                     r_nxt.cp = ptr_inc(r_r.cp);
                  end
                  r_nxt.st = L_TX;
               end else begin
                  r_nxt.sda_oe = r_nxt.ack;
                  r_nxt.st = L_ACK;
               end
            end
         end
         L_ACK: begin
            if (fall) begin
               r_nxt.sda_oe = 1'b0;
               r_nxt.bcnt = 4'h0;
               if (!r_r.ack) begin
                  r_nxt.st = L_IDLE;
               end else if (r_r.rw) begin
                  r_nxt.sh = buf_m ? rd_byte : r_r.tx_hold;
                  r_nxt.sda_oe = ~r_nxt.sh[7];
                  if (buf_m) begin
                     r_nxt.cp = ptr_inc(r_r.cp);
                  end
                  r_nxt.st = L_TX;
               end else begin
                  r_nxt.st = L_RX;
               end
            end
         end
         L_TX: begin
            if (fall) begin
               if (r_r.bcnt == 4'h7) begin
                  r_nxt.sda_oe = 1'b0;
                  r_nxt.st = L_TX_ACK;
               end else begin
                  r_nxt.sh = {r_r.sh[6:0], 1'b0};
                  r_nxt.sda_oe = ~r_r.sh[6];
                  r_nxt.bcnt = r_r.bcnt + 4'h1;
               end
            end
         end
         L_TX_ACK: begin
            if (rise) begin
               r_nxt.mack = ~r_r.sda_s2;
            end else if (fall) begin
               r_nxt.ev_addr = 1'b0;
               r_nxt.to_tx = 1'b1;
               r_nxt.cpu_ack = 1'b0;
               if (!r_r.mack) begin
                  r_nxt.st = L_IDLE;
               end else if (buf_m && !(irq && r_r.flag_s2)) begin
                  r_nxt.ev_tgl = r_r.ev_tgl ^ irq;
                  r_nxt.sh = rd_byte;
                  r_nxt.sda_oe = ~rd_byte[7];
                  r_nxt.cp = ptr_inc(r_r.cp);
                  r_nxt.bcnt = 4'h0;
                  r_nxt.st = L_TX;
               end else begin
                  r_nxt.ev_tgl = r_r.ev_tgl ^ ~buf_m;
                  r_nxt.wait_cpu = ~buf_m;
                  r_nxt.scl_oe = 1'b1;
                  r_nxt.st = L_STALL;
               end
            end
         end
         default: r_nxt.st = L_IDLE;
      endcase
      if (start) begin
         r_nxt.st = L_ADDR;
         r_nxt.bcnt = 4'h0;
         r_nxt.cp = {1'b0, r_r.bp};
         r_nxt.scl_oe = 1'b0;
         r_nxt.sda_oe = 1'b0;
      end else if (stop) begin
         r_nxt.st = L_IDLE;
         r_nxt.busy = 1'b0;
         r_nxt.scl_oe = 1'b0;
         r_nxt.sda_oe = 1'b0;
      end
      if (!en) begin
         r_nxt.st = L_IDLE;
         r_nxt.busy = 1'b0;
         r_nxt.scl_oe = 1'b0;
         r_nxt.sda_oe = 1'b0;
      end
   end

   always_ff @(posedge bus.lnk_clk) begin
      lrst_s1_n <= i_rst_n;
      lrst_s2_n <= lrst_s1_n;
   end

   always_ff @(posedge bus.lnk_clk) begin
      if (!lrst_s2_n) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   always_ff @(posedge bus.lnk_clk) begin
      if (ram_we) begin
         ram[r_r.cp[PTR_W-1:0]] <= r_r.sh;
      end
   end

   always_comb begin
      s_nxt = s_r;
      xstat = 8'h00;
      // unused in compatibility mode, so it reads as zero there
      if (s_r.xcfg != XCFG_RST) begin
         xstat[XSTAT_BUSY_POS] = s_r.busy_s2;
         xstat[XSTAT_DIR_POS] = s_r.dir_s2;
      end
      s_nxt.en = i_enable;
      s_nxt.ev_s1 = r_r.ev_tgl;
      s_nxt.ev_s2 = s_r.ev_s1;
      s_nxt.ev_s3 = s_r.ev_s2;
      s_nxt.busy_s1 = r_r.busy;
      s_nxt.busy_s2 = s_r.busy_s1;
      s_nxt.dir_s1 = r_r.dir;
      s_nxt.dir_s2 = s_r.dir_s1;
      if (i_svc) begin
         s_nxt.flag = 1'b0;
         s_nxt.go_tgl = ~s_r.go_tgl;
         s_nxt.go_ack = i_svc_ack;
         s_nxt.go_data = i_svc_data;
      end
      // a new byte event beats a simultaneous clear
      if (s_r.ev_s2 ^ s_r.ev_s3) begin
         s_nxt.flag = 1'b1;
         s_nxt.addr_flag = r_r.ev_addr;
         s_nxt.rx_byte = r_r.sh;
      end
      if (i_wr) begin
         unique case (i_addr)
            XCFG_OFS: s_nxt.xcfg = i_wdata & XCFG_MASK;
            ADDR_OFS: s_nxt.oaddr = i_wdata & ADDR_MASK;
            default: ;
         endcase
      end
      if (i_rd) begin
         unique case (i_addr)
            XCFG_OFS: s_nxt.rdata = s_r.xcfg;
            XSTAT_OFS: s_nxt.rdata = xstat;
            ADDR_OFS: s_nxt.rdata = s_r.oaddr;
            default: s_nxt.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s_r <= '0;
         s_r.xcfg <= XCFG_RST;
         s_r.oaddr <= ADDR_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus.scl_s_o = 1'b0;
   assign bus.sda_s_o = 1'b0;
   assign bus.scl_s_oe = r_r.scl_oe;
   assign bus.sda_s_oe = r_r.sda_oe;
   assign o_rdata = s_r.rdata;
   assign o_byte_done = s_r.flag;
   assign o_addr_byte = s_r.addr_flag;
   assign o_rx_byte = s_r.rx_byte;
endmodule

// ---- bench/i2cxc_properties.sv ----
// link wire checks on the slave end, sampled by the link clock
`timescale 1ns/10ps
module i2cxc_properties (
   // clock and reset
   input wire logic lnk_clk,
   input wire logic i_rst_n,
   // link wires
   input wire logic scl_s_o,
   input wire logic scl_s_oe,
   input wire logic sda_s_o,
   input wire logic sda_s_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge lnk_clk); endclocking
   default disable iff (!i_rst_n);
   // two high samples of scl, so a data edge is never taken for start or stop
   sequence start_s; $fell(sda) && scl && $past(scl); endsequence
   sequence stop_s; $rose(sda) && scl && $past(scl); endsequence
   a_scl_open_drain: assert property (scl_s_oe |-> !scl_s_o)
      else $error("slave drove scl high");
   a_sda_open_drain: assert property (sda_s_oe |-> !sda_s_o)
      else $error("slave drove sda high");
   a_stall_from_low: assert property ($rose(scl_s_oe) |-> !scl)
      else $error("stall began while scl high");
   a_sda_steady_high: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
      else $error("slave moved sda while scl high");
   a_ack_from_low: assert property ($rose(sda_s_oe) |-> !scl)
      else $error("slave took sda while scl high");
   a_release_low: assert property ($fell(sda_s_oe) |-> !scl)
      else $error("slave let sda go while scl high");
   a_no_early_stall: assert property (start_s |=> !scl_s_oe [*8])
      else $error("stall right after start");
   a_idle_after_stop: assert property (stop_s |=> !(sda_s_oe || scl_s_oe) [*8])
      else $error("slave drove link after stop");
   c_start: cover property (start_s);
   c_stall: cover property ($rose(scl_s_oe));
   c_ack: cover property ($rose(sda_s_oe));
endmodule

// ---- bench/i2c_slave_enhanced_config_tb.sv ----
// bench joining master end and slave end over the link
`timescale 1ns/10ps
module i2c_slave_enhanced_config_tb;
   import i2cxc_pkg::*;
   logic i_clk = 1'b0, i_rst_n = 1'b0, i_enable = 1'b0, i_cmd_valid = 1'b0;
   logic i_wr = 1'b0, i_rd = 1'b0, i_svc = 1'b0, i_svc_ack = 1'b0, rd_d = 1'b0, bd_d = 1'b0;
   logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_svc_data = 8'h00, i_cmd_data = 8'h00;
   i2cxc_cmd_t i_cmd = CMD_STOP;
   logic o_ready, o_rd_valid, o_ack_seen, o_byte_done, o_addr_byte;
   logic [7:0] o_rd_data, o_rdata, o_rx_byte, dat;
   logic [6:0] adr;
   logic [8:0] mq[$], eq[$];
   logic [7:0] rq[$];
   int fails = 0, cmp_count = 0, seed = 32'ha1d53f2e;
   i2cxc_if lnk();
   i2cxc_mst i2cxc_mst_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(lnk),
      .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_cmd_data(i_cmd_data), .o_ready(o_ready),
      .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_ack_seen(o_ack_seen));
   i2cxc_dev i2cxc_dev_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(lnk), .i_enable(i_enable),
      .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
      .o_byte_done(o_byte_done), .o_addr_byte(o_addr_byte), .o_rx_byte(o_rx_byte),
      .i_svc(i_svc), .i_svc_ack(i_svc_ack), .i_svc_data(i_svc_data));
   i2cxc_properties i2cxc_properties_i (.lnk_clk(lnk.lnk_clk), .i_rst_n(i_rst_n),
      .scl_s_o(lnk.scl_s_o), .scl_s_oe(lnk.scl_s_oe), .sda_s_o(lnk.sda_s_o),
      .sda_s_oe(lnk.sda_s_oe), .scl(lnk.scl), .sda(lnk.sda));
   initial begin
      forever #2.5 i_clk = ~i_clk;
   end
   task automatic print_verdict;
      $display("checks %0d errors %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic c, input string m);
      cmp_count++;
      if (!c) begin
         fails++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask
   // bounded wait on o_ready (0) or o_byte_done (1)
   task automatic wait_for(input bit w);
      int n = 0;
      while ((w ? o_byte_done : o_ready) !== 1'b1) begin
         @(negedge i_clk);
         n++;
         if (n > 30000) begin
            fails++;
            print_verdict();
         end
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      i_wr = 1'b1;
      i_addr = a;
      i_wdata = d;
      @(negedge i_clk);
      i_wr = 1'b0;
      repeat (20) @(negedge i_clk);
   endtask
   task automatic rr(input logic [7:0] a, input logic [7:0] e);
      rq.push_back(e);
      @(negedge i_clk);
      i_rd = 1'b1;
      i_addr = a;
      @(negedge i_clk);
      i_rd = 1'b0;
   endtask
   task automatic mcmd(input i2cxc_cmd_t c, input logic [7:0] d, input logic [8:0] e);
      if (c != CMD_STOP)
         mq.push_back(e);
      @(negedge i_clk);
      i_cmd_valid = 1'b1;
      i_cmd = c;
      i_cmd_data = d;
      @(negedge i_clk);
      i_cmd_valid = 1'b0;
      wait_for(1'b0);
   endtask
   // cpu side of one stalled byte
   task automatic svc(input logic ab, input logic [7:0] rx, input logic ak);
      eq.push_back({ab, rx});
      wait_for(1'b1);
      @(negedge i_clk);
      i_svc = 1'b1;
      i_svc_ack = ak;
      @(negedge i_clk);
      i_svc = 1'b0;
   endtask
   task automatic op(input i2cxc_cmd_t c, input logic [7:0] d, input logic [8:0] e,
                     input logic st, input logic ak);
      if (st)
         fork
            mcmd(c, d, e);
            svc(c == CMD_START, d, ak);
         join
      else
         mcmd(c, d, e);
   endtask
   // an unexpected byte event finds the queue empty and fails
   always @(posedge i_clk) begin
      rd_d <= i_rd;
      bd_d <= o_byte_done;
      if (o_rd_valid === 1'b1)
         chk(mq.size() > 0 && {o_ack_seen, o_rd_data} === mq.pop_front(), "bus byte");
      if (o_byte_done === 1'b1 && bd_d === 1'b0)
         chk(eq.size() > 0 && {o_addr_byte, o_rx_byte} === eq.pop_front(), "event");
   end
   always @(negedge i_clk) begin
      if (rd_d)
         chk(o_rdata === rq.pop_front(), "register read");
   end
   initial begin
      adr = 7'($random(seed));
      dat = 8'($random(seed));
      i_svc_data = 8'($random(seed));
      repeat (4) @(negedge i_clk);
      i_rst_n = 1'b1;
      i_enable = 1'b1;
      rr(XCFG_OFS, XCFG_RST);
      rr(XSTAT_OFS, 8'h00);
      rr(ADDR_OFS, ADDR_RST);
      wr(XSTAT_OFS, 8'hff);
      wr(ADDR_OFS, {1'b1, adr});
      wr(XCFG_OFS, 8'hff);
      rr(XCFG_OFS, XCFG_MASK);
      rr(XSTAT_OFS, 8'h00);
      rr(ADDR_OFS, {1'b0, adr});
      rr(8'hcb, 8'h00);
      op(CMD_START, {adr, 1'b0}, {1'b1, adr, 1'b0}, 0, 0);
      rr(XSTAT_OFS, 8'h01);
      op(CMD_WRITE, 8'h1f, 9'h11f, 0, 0);
      op(CMD_WRITE, dat, {1'b1, dat}, 0, 0);
      op(CMD_STOP, 8'h00, 9'h000, 0, 0);
      repeat (20) @(negedge i_clk);
      rr(XSTAT_OFS, 8'h00);
      op(CMD_START, {adr, 1'b1}, {1'b1, adr, 1'b1}, 0, 0);
      rr(XSTAT_OFS, 8'h03);
      op(CMD_READ, 8'h00, {1'b0, dat}, 0, 0);
      op(CMD_STOP, 8'h00, 9'h000, 0, 0);
      op(CMD_START, {adr ^ 7'h01, 1'b0}, {1'b0, adr ^ 7'h01, 1'b0}, 0, 0);
      op(CMD_STOP, 8'h00, 9'h000, 0, 0);
      wr(XCFG_OFS, 8'h0a);
      op(CMD_START, {adr, 1'b0}, {1'b1, adr, 1'b0}, 1, 1);
      op(CMD_WRITE, 8'h00, 9'h100, 0, 0);
      op(CMD_STOP, 8'h00, 9'h000, 0, 0);
      op(CMD_START, {adr, 1'b0}, {1'b0, adr, 1'b0}, 1, 0);
      op(CMD_STOP, 8'h00, 9'h000, 0, 0);
      wr(XCFG_OFS, 8'h09);
      op(CMD_START, {adr, 1'b0}, {1'b1, adr, 1'b0}, 1, 0);
      op(CMD_WRITE, dat, {1'b1, dat}, 1, 1);
      op(CMD_STOP, 8'h00, 9'h000, 0, 0);
      wr(XCFG_OFS, 8'h08);
      op(CMD_START, {~adr, 1'b0}, {1'b1, ~adr, 1'b0}, 1, 1);
      op(CMD_WRITE, ~dat, {1'b1, ~dat}, 1, 1);
      op(CMD_STOP, 8'h00, 9'h000, 0, 0);
      print_verdict();
   end
endmodule
